/* File: fpw_mapper.sv */
// page index register, flash windows and emulation port
// ---------------------------------------------
// Behaviour
// - three-bit page index selects active pages
// - 16K window at 8000, eight pages
// - bits 2:1 array, bit 0 half
// - flash register window by bits 2:1
// - special test bit gives 32K window
// - test window index acts as x16 x15
// - port data accessible unless unmapped, emul pins kept
// - bit7 select, bits2:0 index, 6:4 zero
// - port unmapped when expanded and emulating
// - select low on window flash/external access
// - select in e high, stretched external
// - select driven only with emulation enabled
// - index pins show page register contents
// - direction 0 input, 1 output
// - inputs selectable high-z or pull-up
// - page register reads zero above bit 2
// - dedicated call/return page path
// - register block beats flash
// - test window only in special modes
// ---------------------------------------------
module fpw_mapper #(
    parameter int ADR_W = 12
) (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 ce,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [ADR_W-1:0]     wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // cpu access to decode
    input  wire logic                 cpu_valid,
    input  wire logic [15:0]          cpu_addr,
    input  wire logic                 reg_space_hit,
    input  wire logic                 e_high,
    // call/return page path
    input  wire logic                 call_page_we,
    input  wire logic [2:0]           call_page_data,
    output logic      [2:0]           page_index_bits,
    // decode results
    output logic                      flash_sel,
    output logic      [16:0]          flash_addr,
    output logic                      flash_reg_sel,
    output logic      [1:0]           flash_reg_page,
    output logic                      ext_sel,
    // emulation port pins
    input  wire logic [7:0]           port_pin_in,
    output logic      [7:0]           port_pin_out,
    output logic      [7:0]           port_pin_oe_n,
    output logic                      port_pull_up
);
    // ---------------------------------------------
    // registers
    // ---------------------------------------------
    logic [2:0] page_r;
    logic [7:0] ctrl_r;
    logic [7:0] pdata_r;
    logic [7:0] pdir_r;
    logic [7:0] sync1_r;
    logic [7:0] sync2_r;
    logic       ack_r;
    logic [1:0] str_cnt_r;
    logic       e_prev_r;
    logic       cs_hold_r;
    logic       cs_n_r;

    // ---------------------------------------------
    // bus decode
    // ---------------------------------------------
    logic       req;
    logic       wr;
    logic [7:0] idx;
    logic       port_mapped;
    logic       test_win;
    logic       emul;
    localparam int ADR_LSB = fpw_pkg::ADR_LSB;

    assign req  = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr   = req && wb_we_i && wb_sel_i[0];
    assign idx  = wb_adr_i[ADR_LSB+7:ADR_LSB];
    assign emul = ctrl_r[fpw_pkg::CTL_EMUL];
    // port vanishes in expanded modes while emulating
    assign port_mapped = !(ctrl_r[fpw_pkg::CTL_EXPAND] && emul);
    // test bit has no effect outside special mode
    assign test_win = ctrl_r[fpw_pkg::CTL_TEST]
                    && ctrl_r[fpw_pkg::CTL_SPECIAL];

    // ---------------------------------------------
    // address functions
    // ---------------------------------------------
    // flat 128K flash address for a cpu address and page
    function automatic logic [16:0] win_addr(
        input logic [15:0] a,
        input logic [2:0]  p,
        input logic        t
    );
        if (t) begin
            win_addr = {p[2:1], a[14:0]};
        end else begin
            win_addr = {p, a[13:0]};
        end
    endfunction

    // the program window covers 8000-BFFF or 8000-FFFF
    function automatic logic in_window(
        input logic [15:0] a,
        input logic        t
    );
        if (t) begin
            in_window = a[15];
        end else begin
            in_window = (a[15:14] == fpw_pkg::WIN_Q);
        end
    endfunction

    // ---------------------------------------------
    // read mux of pin sample and latch
    // ---------------------------------------------
    logic [7:0] port_rd;
    logic [7:0] rd_val;
    assign port_rd = ((pdata_r & pdir_r) | (sync2_r & ~pdir_r))
                   & fpw_pkg::PORT_MASK;

    always_comb begin
        rd_val = 8'h00;
        unique case (idx)
            fpw_pkg::IDX_PORT_DATA: rd_val = port_mapped ? port_rd : 8'h00;
            fpw_pkg::IDX_PORT_DIR:  rd_val = port_mapped ? (pdir_r & fpw_pkg::PORT_MASK) : 8'h00;
            fpw_pkg::IDX_PAGE:      rd_val = {5'h00, page_r};
            fpw_pkg::IDX_CTRL:      rd_val = ctrl_r;
            default:                rd_val = 8'h00;
        endcase
    end

    // ---------------------------------------------
    // wishbone answer, one wait-free cycle
    // ---------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ack_r    <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce) begin
            ack_r    <= req;
            wb_ack_o <= req;
            if (req) begin
                wb_dat_o <= {24'h00_0000, rd_val};
            end
        end
    end

    // ---------------------------------------------
    // page index register
    // ---------------------------------------------
    // the call path wins: an instruction in flight owns the page
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            page_r <= fpw_pkg::PAGE_RST[2:0];
        end else if (ce) begin
            if (call_page_we) begin
                page_r <= call_page_data;
            end else if (wr && idx == fpw_pkg::IDX_PAGE) begin
                page_r <= wb_dat_i[2:0];
            end
        end
    end
    assign page_index_bits = page_r;

    // ---------------------------------------------
    // control register
    // ---------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_r <= fpw_pkg::CTRL_RST;
        end else if (ce && wr && idx == fpw_pkg::IDX_CTRL) begin
            ctrl_r <= wb_dat_i[7:0];
        end
    end

    // ---------------------------------------------
    // port data and direction
    // ---------------------------------------------
    // writes land in the latch only while the port is mapped; the pin mux hides it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pdata_r <= fpw_pkg::PORT_RST;
            pdir_r  <= fpw_pkg::PORT_RST;
        end else if (ce && wr && port_mapped) begin
            if (idx == fpw_pkg::IDX_PORT_DATA) begin
                pdata_r <= wb_dat_i[7:0] & fpw_pkg::PORT_MASK;
            end
            if (idx == fpw_pkg::IDX_PORT_DIR) begin
                pdir_r <= wb_dat_i[7:0] & fpw_pkg::PORT_MASK;
            end
        end
    end

    // pins come from outside the clock domain
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
        end else if (ce) begin
            sync1_r <= port_pin_in;
            sync2_r <= sync1_r;
        end
    end

    // ---------------------------------------------
    // address decode, registered
    // ---------------------------------------------
    logic       map_en;
    logic       win_hit;
    logic       fix_hit;
    logic       fl_hit;
    logic       ex_hit;
    logic       freg_hit;
    logic [2:0] fix_page;
    assign map_en  = ctrl_r[fpw_pkg::CTL_MAP_EN];
    assign win_hit = cpu_valid && in_window(cpu_addr, test_win);
    // fixed copies of pages 6 and 7, absent under the test window
    assign fix_hit = cpu_valid && !test_win
                   && (cpu_addr[15:14] == fpw_pkg::FIX_LO_Q
                    || cpu_addr[15:14] == fpw_pkg::FIX_HI_Q);
    assign fix_page = cpu_addr[15] ? fpw_pkg::PAGE_HI : fpw_pkg::PAGE_LO;
    // the register block hides any flash byte under it
    assign fl_hit  = map_en && !reg_space_hit && (win_hit || fix_hit);
    assign ex_hit  = ctrl_r[fpw_pkg::CTL_EXPAND] && cpu_valid
                   && !reg_space_hit && !fl_hit;
    assign freg_hit = cpu_valid && reg_space_hit
                    && (cpu_addr[9:2] == fpw_pkg::FREG_BASE[9:2]);

    // page change reaches the next access after the write
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flash_sel      <= 1'b0;
            flash_addr     <= 17'h0_0000;
            flash_reg_sel  <= 1'b0;
            flash_reg_page <= 2'h0;
            ext_sel        <= 1'b0;
        end else if (ce) begin
            flash_sel      <= fl_hit;
            flash_addr     <= win_hit ? win_addr(cpu_addr, page_r, test_win)
                                      : win_addr(cpu_addr, fix_page, 1'b0);
            flash_reg_sel  <= freg_hit;
            flash_reg_page <= page_r[2:1];
            ext_sel        <= ex_hit;
        end
    end

    // ---------------------------------------------
    // window chip select with external stretch
    // ---------------------------------------------
    logic e_fall;
    logic cs_now;
    logic hold_start;
    assign e_fall = e_prev_r && !e_high;
    assign cs_now = win_hit && (fl_hit || ex_hit) && e_high;
    // the select must not blink high in the cycle the stretch begins
    assign hold_start = e_fall && win_hit && ex_hit
                      && ctrl_r[fpw_pkg::CTL_STR_HI:fpw_pkg::CTL_STR_LO] != 2'h0;

    // stretch counts whole e periods after the first high phase
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            e_prev_r  <= 1'b0;
            str_cnt_r <= 2'h0;
            cs_hold_r <= 1'b0;
        end else if (ce) begin
            e_prev_r <= e_high;
            if (e_fall && cs_hold_r) begin
                if (str_cnt_r == 2'h0) begin
                    cs_hold_r <= 1'b0;
                end else begin
                    str_cnt_r <= str_cnt_r - 2'h1;
                end
            end else if (hold_start) begin
                cs_hold_r <= 1'b1;
                str_cnt_r <= ctrl_r[fpw_pkg::CTL_STR_HI:fpw_pkg::CTL_STR_LO] - 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cs_n_r <= 1'b1;
        end else if (ce) begin
            cs_n_r <= !(emul && (cs_now || cs_hold_r || hold_start));
        end
    end

    // ---------------------------------------------
    // pin drive
    // ---------------------------------------------
    // emulation pins ignore direction and the data latch
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            port_pin_out  <= 8'h00;
            port_pin_oe_n <= 8'hFF;
            port_pull_up  <= 1'b0;
        end else if (ce) begin
            port_pull_up <= ctrl_r[fpw_pkg::CTL_PULL];
            for (int i = 0; i < 8; i++) begin
                if (emul && fpw_pkg::EMUL_MASK[i]) begin
                    port_pin_oe_n[i] <= 1'b0;
                    port_pin_out[i]  <= (i == fpw_pkg::PIN_CS) ? cs_n_r : page_r[i%3];
                end else begin
                    port_pin_oe_n[i] <= !(pdir_r[i] && fpw_pkg::PORT_MASK[i]);
                    port_pin_out[i]  <= pdata_r[i];
                end
            end
        end
    end

    // ---------------------------------------------
    // assertions
    // ---------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_ack_one_cycle: assert property (ce && wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_page_upper_zero: assert property (
        wb_ack_o && $past(idx) == fpw_pkg::IDX_PAGE && !$past(wb_we_i)
        |-> wb_dat_o[7:3] == 5'h00)
        else $error("page register upper bits not zero");
    a_page_write: assert property (
        ce && wr && idx == fpw_pkg::IDX_PAGE && !call_page_we
        |=> page_r == $past(wb_dat_i[2:0]))
        else $error("page write lost");
    a_call_path: assert property (ce && call_page_we
        |=> page_index_bits == $past(call_page_data))
        else $error("call path page write lost");
    a_test_special: assert property (
        !ctrl_r[fpw_pkg::CTL_SPECIAL] |-> !test_win)
        else $error("test window outside special mode");
    a_flash_addr: assert property (
        ce && fl_hit && win_hit && !test_win
        |=> flash_sel && flash_addr[16:14] == $past(page_r))
        else $error("window page not applied");
    a_reg_priority: assert property (
        ce && reg_space_hit |=> !flash_sel)
        else $error("flash selected under register block");
    a_cs_disabled: assert property (
        ce && !emul |=> cs_n_r)
        else $error("select driven without emulation");
    a_emul_index: assert property (
        ce && emul |=> port_pin_out[2:0] == $past(page_r))
        else $error("index pins not following page");
    a_port_hidden: assert property (
        wb_ack_o && !$past(port_mapped) && $past(idx) == fpw_pkg::IDX_PORT_DIR
        |-> wb_dat_o == 32'h0000_0000)
        else $error("direction visible while unmapped");
    a_cs_stretch: assert property (
        ce && emul && cs_hold_r |=> !cs_n_r)
        else $error("select released during stretch");
    a_stretch_start: assert property (
        ce && hold_start && !cs_hold_r |=> cs_hold_r)
        else $error("stretch not started on external access");

    c_test_window: cover property (ce && test_win && fl_hit);
    c_stretch: cover property (cs_hold_r ##1 cs_hold_r ##1 cs_hold_r);
    c_emul_cs: cover property (emul && !cs_n_r);
    c_ext_window: cover property (ce && hold_start);
endmodule

/* File: fpw_mapper_test.sv */
// self-checking bench for the page window mapper
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; \
    $display("BAD t=%0t got %h exp %h", $time, got, exp); end end
module fpw_mapper_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_b = 0, ce = 1, cyc = 0, stb = 0, we = 0, cpu_valid = 0, hit = 0, cpw = 0;
    logic [11:0] adr = 0;
    logic [31:0] wdat = 0, rdat, dat_o;
    logic [15:0] cpu_addr = 0;
    logic [2:0] cpd = 0, page;
    logic [7:0] pin, p_out, p_oe_n, ext_drv = 0, ext_val = 0;
    logic ack, e_high, fsel, frsel, esel, pull;
    logic [16:0] faddr;
    logic [1:0] frpage;
    int fails = 0, checks_done = 0, cyc_cnt = 0, n;
    always #25 clk = ~clk;
    fpw_mapper DUT (.clk(clk), .rst_b(rst_b), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .cpu_valid(cpu_valid), .cpu_addr(cpu_addr), .reg_space_hit(hit),
        .e_high(e_high), .call_page_we(cpw), .call_page_data(cpd), .page_index_bits(page),
        .flash_sel(fsel), .flash_addr(faddr), .flash_reg_sel(frsel), .flash_reg_page(frpage),
        .ext_sel(esel), .port_pin_in(pin), .port_pin_out(p_out), .port_pin_oe_n(p_oe_n),
        .port_pull_up(pull));
    fpw_pin_model PM (.clk(clk), .rst_b(rst_b), .pin_out(p_out), .pin_oe_n(p_oe_n),
        .pull_up(pull), .ext_drv(ext_drv), .ext_val(ext_val), .e_high(e_high), .pin(pin));
    // ----------------------------------------
    // bus and access tasks
    // ----------------------------------------
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= {2'h0, idx, 2'h0};
        wdat <= {24'h0, d};
        // only the global watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 0;
        stb <= 0;
        @(posedge clk);
    endtask
    // cpu access held for len cycles, outputs settled after the last edge
    task automatic access(input logic [15:0] a, input logic h, input int len);
        @(posedge clk);
        cpu_addr <= a;
        cpu_valid <= 1;
        hit <= h;
        repeat (len) @(posedge clk);
        cpu_valid <= 0;
        hit <= 0;
        #1;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // hang guard well above the expected run
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt >= 5000) begin
            fails++;
            results();
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_and_page;
        bus(0, fpw_pkg::IDX_PAGE, 0); `CHK(rdat[7:0], 8'h00)
        bus(0, fpw_pkg::IDX_CTRL, 0); `CHK(rdat[7:0], fpw_pkg::CTRL_RST)
        `CHK(p_oe_n, 8'hFF)
        bus(0, 8'h10, 0); `CHK(rdat, 32'h0)
        bus(1, fpw_pkg::IDX_PAGE, 8'hFF);
        bus(0, fpw_pkg::IDX_PAGE, 0); `CHK(rdat[7:0], 8'h07)
        `CHK(page, 3'h7)
    endtask
    task automatic t_decode;
        bus(1, fpw_pkg::IDX_CTRL, 8'h31);
        bus(1, fpw_pkg::IDX_PAGE, 8'h05);
        access(16'h8123, 0, 1); `CHK({fsel, faddr}, {1'b1, 17'h14123})
        access(16'h4010, 0, 1); `CHK(faddr, 17'h18010)
        access(16'hC010, 0, 1); `CHK(faddr, 17'h1C010)
        access(16'h8123, 1, 1); `CHK(fsel, 1'b0)
        access(16'h00F6, 1, 1); `CHK({frsel, frpage}, 3'b110)
        bus(1, fpw_pkg::IDX_CTRL, 8'h43);
        access(16'hC456, 0, 1); `CHK(faddr, 17'h14456)
        bus(1, fpw_pkg::IDX_CTRL, 8'h03);
        access(16'hC456, 0, 1); `CHK(faddr, 17'h1C456)
    endtask
    task automatic t_call_path;
        @(posedge clk);
        cpw <= 1;
        cpd <= 3'h3;
        @(posedge clk);
        cpw <= 0;
        #1;
        `CHK(page, 3'h3)
        bus(0, fpw_pkg::IDX_PAGE, 0); `CHK(rdat[7:0], 8'h03)
        // clock enable low must freeze the page even against the call path
        ce <= 0;
        cpw <= 1;
        cpd <= 3'h6;
        @(posedge clk);
        cpw <= 0;
        ce <= 1;
        #1;
        `CHK(page, 3'h3)
    endtask
    task automatic t_emulation;
        bus(1, fpw_pkg::IDX_CTRL, 8'h01);
        access(16'h8000, 0, 4); `CHK(p_oe_n[7], 1'b1)
        bus(1, fpw_pkg::IDX_CTRL, 8'h05);
        bus(1, fpw_pkg::IDX_PAGE, 8'h05);
        repeat (3) @(posedge clk);
        #1;
        `CHK({p_oe_n[7], p_oe_n[2:0], p_out[2:0]}, 7'h05)
        bus(1, fpw_pkg::IDX_PORT_DATA, 8'h02);
        repeat (2) @(posedge clk);
        #1;
        `CHK(p_out[2:0], 3'h5)
        `CHK(p_out[7], 1'b1)
        fork
            access(16'h8000, 0, 4);
            begin
                n = 0;
                repeat (8) begin
                    @(posedge clk);
                    #1;
                    if (p_out[7] === 1'b0) n = 1;
                end
            end
        join
        `CHK(n, 1)
        bus(1, fpw_pkg::IDX_PORT_DIR, 8'h08);
        bus(1, fpw_pkg::IDX_CTRL, 8'h85);
        bus(0, fpw_pkg::IDX_PORT_DIR, 0); `CHK(rdat[7:0], 8'h00)
    endtask
    // external window access with three stretch periods keeps the select low
    task automatic t_stretch;
        int run;
        int best;
        run = 0;
        best = 0;
        bus(1, fpw_pkg::IDX_CTRL, 8'hB4);
        fork
            begin
                access(16'h8000, 0, 8);
                `CHK(esel, 1'b1)
            end
            repeat (28) begin
                @(posedge clk);
                #1;
                run = (p_out[7] === 1'b0) ? run + 1 : 0;
                if (run > best) best = run;
            end
        join
        `CHK(best inside {[13:16]}, 1'b1)
    endtask
    // a second reset in mid-run returns page and control to reset values
    task automatic t_mid_reset;
        @(posedge clk);
        rst_b <= 0;
        repeat (2) @(posedge clk);
        rst_b <= 1;
        bus(0, fpw_pkg::IDX_PAGE, 0); `CHK(rdat[7:0], 8'h00)
        bus(0, fpw_pkg::IDX_CTRL, 0); `CHK(rdat[7:0], fpw_pkg::CTRL_RST)
        `CHK(p_oe_n, 8'hFF)
    endtask
    task automatic t_gp_port;
        bus(1, fpw_pkg::IDX_CTRL, 8'h08);
        bus(1, fpw_pkg::IDX_PORT_DIR, 8'h08);
        bus(1, fpw_pkg::IDX_PORT_DATA, 8'h78);
        #1;
        `CHK({p_oe_n[3], p_out[3], pull}, 3'b011)
        bus(0, fpw_pkg::IDX_PORT_DATA, 0); `CHK(rdat[7:3], 5'h11)
        bus(1, fpw_pkg::IDX_PORT_DIR, 8'h00);
        bus(1, fpw_pkg::IDX_CTRL, 8'h00);
        ext_drv <= 8'h08;
        for (int v = 0; v < 2; v++) begin
            ext_val <= v[0] ? 8'h08 : 8'h00;
            repeat (4) @(posedge clk);
            bus(0, fpw_pkg::IDX_PORT_DATA, 0); `CHK(rdat[3], v[0])
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1;
        t_reset_and_page();
        t_decode();
        t_call_path();
        t_emulation();
        t_stretch();
        t_gp_port();
        t_mid_reset();
        results();
    end
endmodule

/* File: fpw_pin_model.sv */
// far side model: e clock source and port pin wires
module fpw_pin_model (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic       pull_up,
    input  wire logic [7:0] ext_drv,
    input  wire logic [7:0] ext_val,
    output logic            e_high,
    output logic [7:0]      pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] e_cnt_r;
    logic [7:0] last_r;
    // e clock: two cycles high, two low
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            e_cnt_r <= 2'h0;
        end else begin
            e_cnt_r <= e_cnt_r + 2'h1;
        end
    end
    assign e_high = e_cnt_r[1];
    // released pins with no pull-up or outside drive never hold their last level, so stale reads show up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) begin
                pin[i] = pin_out[i];
            end else if (ext_drv[i]) begin
                pin[i] = ext_val[i];
            end else if (pull_up) begin
                pin[i] = 1'b1;
            end else begin
                pin[i] = ~last_r[i];
            end
        end
    end
    // reset keeps the floating level known instead of stuck unknown
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            last_r <= 8'h00;
        end else begin
            last_r <= pin;
        end
    end
endmodule

/* File: fpw_pkg.sv */
// constants for the flash page window mapper
package fpw_pkg;
    // ---------------------------------------------
    // register indices, byte address = 4 * index
    // ---------------------------------------------
    localparam logic [7:0] IDX_PORT_DATA = 8'hFC;
    localparam logic [7:0] IDX_PORT_DIR  = 8'hFD;
    localparam logic [7:0] IDX_PAGE      = 8'hF0;
    localparam logic [7:0] IDX_CTRL      = 8'hF1;
    localparam int         ADR_LSB       = 2;
    // ---------------------------------------------
    // control register fields
    // ---------------------------------------------
    localparam int CTL_MAP_EN  = 0;
    localparam int CTL_TEST    = 1;
    localparam int CTL_EMUL    = 2;
    localparam int CTL_PULL    = 3;
    localparam int CTL_STR_LO  = 4;
    localparam int CTL_STR_HI  = 5;
    localparam int CTL_SPECIAL = 6;
    localparam int CTL_EXPAND  = 7;
    localparam logic [7:0] CTRL_RST  = 8'h30;
    localparam logic [7:0] PAGE_RST  = 8'h00;
    localparam logic [7:0] PORT_RST  = 8'h00;
    // ---------------------------------------------
    // port pin roles and live bit mask
    // ---------------------------------------------
    localparam int         PIN_CS    = 7;
    localparam int         PIN_GP3   = 3;
    localparam logic [7:0] PORT_MASK = 8'h8F;
    localparam logic [7:0] EMUL_MASK = 8'h87;
    // ---------------------------------------------
    // address map
    // ---------------------------------------------
    localparam logic [1:0] WIN_Q     = 2'h2;
    localparam logic [1:0] FIX_LO_Q  = 2'h1;
    localparam logic [1:0] FIX_HI_Q  = 2'h3;
    localparam logic [2:0] PAGE_LO   = 3'h6;
    localparam logic [2:0] PAGE_HI   = 3'h7;
    localparam logic [9:0] FREG_BASE = 10'h0F4;
    localparam int         PAGE_W    = 3;
    localparam int         FADR_W    = 17;
endpackage
